/* rtl/dsprf_top.sv */
/*
 * DSP register file: accumulators with guard bits, operand registers,
 * the DSP condition status register and the condition bit.
 * Assumes the pipeline presents at most one of each request per cycle.
 */
`timescale 1ns/1ps
module dsprf_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Single-data transfer over the load bus
	input  wire logic        xfer_valid,
	input  wire logic        xfer_load,
	input  wire logic        xfer_long,
	input  wire logic [3:0]  xfer_reg,
	input  wire logic [31:0] xfer_wdata,
	output logic [31:0]      xfer_rdata,
	// DSP operation result write-back
	input  wire logic        op_valid,
	input  wire logic        op_cond,
	input  wire logic [2:0]  op_class,
	input  wire logic [3:0]  op_dst,
	input  wire logic [39:0] op_result,
	input  wire logic        op_carry,
	input  wire logic        op_ovf,
	// Operand source read
	input  wire logic        src_valid,
	input  wire logic [2:0]  src_class,
	input  wire logic [3:0]  src_sel,
	output logic [39:0]      src_data,
	output logic             src_refuse,
	// Status register as system register
	input  wire logic        sys_valid,
	input  wire logic        sys_write,
	input  wire logic [31:0] sys_wdata,
	output logic [31:0]      sys_rdata,
	output logic             condition_bit,
	// CPU status load filter
	input  wire logic        sr_load_valid,
	input  wire logic        dsp_user_mode,
	input  wire logic [31:0] sr_cur,
	input  wire logic [31:0] sr_wdata,
	output logic [31:0]      sr_load_value,
	output logic             sr_load_strobe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [39:0]      acc0;
		logic [39:0]      acc1;
		logic [5:0][31:0] opr;
		logic             gt;
		logic             z;
		logic             n;
		logic             v;
		logic             cy;
		logic [2:0]       cs;
		logic             dc;
		logic [31:0]      xfer_rdata;
		logic [31:0]      sys_rdata;
		logic [39:0]      src_data;
		logic             src_refuse;
		logic [31:0]      sr_load_value;
		logic             sr_load_strobe;
	} dsprf_state_t;

	dsprf_state_t st_reg;
	dsprf_state_t st_next;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Shape a result for an accumulator destination
	function automatic logic [39:0] acc_shape(
		input logic [2:0]  cls,
		input logic [39:0] r
	);
		case (cls)
			dsprf_pkg::OP_FIXED, dsprf_pkg::OP_ASHIFT,
			dsprf_pkg::OP_SMUL:
				acc_shape = r;
			dsprf_pkg::OP_INTEGER, dsprf_pkg::OP_MSBDET:
				acc_shape = {{8{r[31]}}, r[31:16], 16'h0000};
			default:
				acc_shape = {8'h00, r[31:16], 16'h0000};
		endcase
	endfunction

	// Shape a result for an operand register destination
	function automatic logic [31:0] opr_shape(
		input logic [2:0]  cls,
		input logic [39:0] r
	);
		case (cls)
			dsprf_pkg::OP_FIXED, dsprf_pkg::OP_ASHIFT,
			dsprf_pkg::OP_SMUL:
				opr_shape = r[31:0];
			default:
				opr_shape = {r[31:16], 16'h0000};
		endcase
	endfunction

	// Present an operand register to the ALU
	function automatic logic [39:0] opr_src(
		input logic [2:0]  cls,
		input logic [31:0] v
	);
		case (cls)
			dsprf_pkg::OP_FIXED, dsprf_pkg::OP_ASHIFT,
			dsprf_pkg::OP_MSBDET:
				opr_src = {{8{v[31]}}, v};
			dsprf_pkg::OP_INTEGER:
				opr_src = {{8{v[31]}}, v[31:16], 16'h0000};
			default:
				opr_src = {8'h00, v[31:16], 16'h0000};
		endcase
	endfunction

	// Present an accumulator to the ALU
	function automatic logic [39:0] acc_src(
		input logic [2:0]  cls,
		input logic [39:0] a
	);
		case (cls)
			dsprf_pkg::OP_FIXED, dsprf_pkg::OP_ASHIFT,
			dsprf_pkg::OP_MSBDET:
				acc_src = a;
			dsprf_pkg::OP_INTEGER:
				acc_src = {a[39:16], 16'h0000};
			default:
				acc_src = {8'h00, a[31:16], 16'h0000};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Flag candidates and condition bit
	// ------------------------------------------------------------
	logic       op_go;
	logic       flag_upd;
	logic       sys_wr;
	logic       res_z;
	logic       res_n;
	logic       c_gt;
	logic       c_z;
	logic       c_n;
	logic       c_v;
	logic       c_cy;
	logic [2:0] c_cs;
	logic       c_dc;
	logic [31:0] sr_merged;

	// Write allowed only when unconditional or condition holds
	assign op_go    = op_valid & (~op_cond | st_reg.dc);
	// Flags move on unconditional non-multiply operations only
	assign flag_upd = op_valid & ~op_cond
		& (op_class != dsprf_pkg::OP_SMUL);
	assign sys_wr   = sys_valid & sys_write;
	assign res_z    = (op_result == 40'h0000000000);
	assign res_n    = op_result[39];

	// System write takes priority over an operation in the same cycle
	always_comb
	begin
		c_gt = st_reg.gt;
		c_z  = st_reg.z;
		c_n  = st_reg.n;
		c_v  = st_reg.v;
		c_cy = st_reg.cy;
		c_cs = st_reg.cs;
		if (sys_wr)
		begin
			c_gt = sys_wdata[dsprf_pkg::GT_BIT];
			c_z  = sys_wdata[dsprf_pkg::Z_BIT];
			c_n  = sys_wdata[dsprf_pkg::N_BIT];
			c_v  = sys_wdata[dsprf_pkg::V_BIT];
			c_cs = sys_wdata[dsprf_pkg::CS_LSB +: 3];
		end
		else if (flag_upd)
		begin
			c_gt = ~res_n & ~res_z;
			c_z  = res_z;
			c_n  = res_n;
			c_v  = op_ovf;
			c_cy = op_carry;
		end
	end

	dsprf_cond u_cond (
		.gt (c_gt),
		.z  (c_z),
		.n  (c_n),
		.v  (c_v),
		.cy (c_cy),
		.cs (c_cs),
		.dc (c_dc)
	);

	dsprf_sr_guard u_sr_guard (
		.sr_cur        (sr_cur),
		.sr_wdata      (sr_wdata),
		.dsp_user_mode (dsp_user_mode),
		.sr_merged     (sr_merged)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [3:0] oi;
		logic [3:0] ti;
		logic [3:0] si;
		logic [31:0] body;
		st_next = st_reg;
		oi = op_dst - 4'(dsprf_pkg::OPR_BASE);
		ti = xfer_reg - 4'(dsprf_pkg::OPR_BASE);
		si = src_sel - 4'(dsprf_pkg::OPR_BASE);
		body = 32'h00000000;
		st_next.sr_load_strobe = sr_load_valid;
		// CPU status load through the protection filter
		if (sr_load_valid)
			st_next.sr_load_value = sr_merged;
		// DSP result write-back
		if (op_go)
		begin
			case (op_dst)
				dsprf_pkg::REG_ACC0:
					st_next.acc0 = acc_shape(op_class, op_result);
				dsprf_pkg::REG_ACC1:
					st_next.acc1 = acc_shape(op_class, op_result);
				dsprf_pkg::REG_GRD0, dsprf_pkg::REG_GRD1: ;
				default:
					if (oi < 4'h6)
						st_next.opr[oi[2:0]] =
							opr_shape(op_class, op_result);
			endcase
		end
		// Flags and condition bit
		st_next.gt = c_gt;
		st_next.z  = c_z;
		st_next.n  = c_n;
		st_next.v  = c_v;
		st_next.cy = c_cy;
		st_next.cs = c_cs;
		if (flag_upd || sys_wr)
			st_next.dc = c_dc;
		// Single-data transfer
		if (xfer_valid)
		begin
			if (xfer_long)
				body = xfer_wdata;
			else
				body = {xfer_wdata[15:0], 16'h0000};
			if (xfer_load)
			begin
				case (xfer_reg)
					dsprf_pkg::REG_ACC0:
						st_next.acc0 = {{8{body[31]}}, body};
					dsprf_pkg::REG_ACC1:
						st_next.acc1 = {{8{body[31]}}, body};
					dsprf_pkg::REG_GRD0:
						st_next.acc0[39:32] = xfer_wdata[7:0];
					dsprf_pkg::REG_GRD1:
						st_next.acc1[39:32] = xfer_wdata[7:0];
					default:
						if (ti < 4'h6)
							st_next.opr[ti[2:0]] = body;
				endcase
			end
			else
			begin
				case (xfer_reg)
					dsprf_pkg::REG_ACC0: body = st_reg.acc0[31:0];
					dsprf_pkg::REG_ACC1: body = st_reg.acc1[31:0];
					dsprf_pkg::REG_GRD0:
						body = {{24{st_reg.acc0[39]}}, st_reg.acc0[39:32]};
					dsprf_pkg::REG_GRD1:
						body = {{24{st_reg.acc1[39]}}, st_reg.acc1[39:32]};
					default:
						body = (ti < 4'h6) ? st_reg.opr[ti[2:0]]
							: 32'h00000000;
				endcase
				if (xfer_long || xfer_reg == dsprf_pkg::REG_GRD0
					|| xfer_reg == dsprf_pkg::REG_GRD1)
					st_next.xfer_rdata = body;
				else
					st_next.xfer_rdata = {{16{body[31]}}, body[31:16]};
			end
		end
		// Operand source read
		if (src_valid)
		begin
			st_next.src_refuse = 1'b0;
			case (src_sel)
				dsprf_pkg::REG_ACC0:
					if (src_class == dsprf_pkg::OP_SMUL)
					begin
						st_next.src_refuse = 1'b1;
						st_next.src_data   = 40'h0000000000;
					end
					else
						st_next.src_data = acc_src(src_class, st_reg.acc0);
				dsprf_pkg::REG_ACC1:
					st_next.src_data = acc_src(src_class, st_reg.acc1);
				default:
					if (si < 4'h6)
						st_next.src_data =
							opr_src(src_class, st_reg.opr[si[2:0]]);
					else
					begin
						st_next.src_refuse = 1'b1;
						st_next.src_data   = 40'h0000000000;
					end
			endcase
		end
		// Status register store
		if (sys_valid && !sys_write)
			st_next.sys_rdata = {24'h000000, st_reg.gt, st_reg.z,
				st_reg.n, st_reg.v, st_reg.cs, st_reg.dc};
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			st_reg    <= '0;
			st_reg.cs <= dsprf_pkg::DSR_RESET[3:1];
			st_reg.dc <= dsprf_pkg::DSR_RESET[0];
		end
		else
			st_reg <= st_next;
	end

	// Outputs straight from the state
	assign xfer_rdata     = st_reg.xfer_rdata;
	assign src_data       = st_reg.src_data;
	assign src_refuse     = st_reg.src_refuse;
	assign sys_rdata      = st_reg.sys_rdata;
	assign condition_bit  = st_reg.dc;
	assign sr_load_value  = st_reg.sr_load_value;
	assign sr_load_strobe = st_reg.sr_load_strobe;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_rsv_zero;
		@(posedge ref_clk) disable iff (srst)
		sys_rdata[31:8] == 24'h000000;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved status bits not zero");

	property p_word_acc;
		@(posedge ref_clk) disable iff (srst)
		xfer_valid && xfer_load && !xfer_long
			&& xfer_reg == dsprf_pkg::REG_ACC0
		|=> st_reg.acc0 == {{8{$past(xfer_wdata[15])}},
			$past(xfer_wdata[15:0]), 16'h0000};
	endproperty
	a_word_acc: assert property (p_word_acc)
		else $error("word load into accumulator misshaped");

	property p_long_acc;
		@(posedge ref_clk) disable iff (srst)
		xfer_valid && xfer_load && xfer_long
			&& xfer_reg == dsprf_pkg::REG_ACC1
		|=> st_reg.acc1 == {{8{$past(xfer_wdata[31])}},
			$past(xfer_wdata)};
	endproperty
	a_long_acc: assert property (p_long_acc)
		else $error("long load into accumulator misshaped");

	property p_guard_only;
		@(posedge ref_clk) disable iff (srst)
		xfer_valid && xfer_load && xfer_reg == dsprf_pkg::REG_GRD0
			&& !(op_go && op_dst == dsprf_pkg::REG_ACC0)
		|=> st_reg.acc0[31:0] == $past(st_reg.acc0[31:0])
			&& st_reg.acc0[39:32] == $past(xfer_wdata[7:0]);
	endproperty
	a_guard_only: assert property (p_guard_only)
		else $error("guard load disturbed accumulator body");

	property p_cond_block;
		@(posedge ref_clk) disable iff (srst)
		op_valid && op_cond && !condition_bit && !xfer_valid
		|=> $stable({st_reg.acc0, st_reg.acc1, st_reg.opr});
	endproperty
	a_cond_block: assert property (p_cond_block)
		else $error("suppressed operation wrote accumulator");

	property p_cond_nostat;
		@(posedge ref_clk) disable iff (srst)
		op_valid && op_cond && !sys_wr
		|=> $stable({st_reg.gt, st_reg.z, st_reg.n, st_reg.v,
			st_reg.cy, st_reg.cs, st_reg.dc});
	endproperty
	a_cond_nostat: assert property (p_cond_nostat)
		else $error("conditional operation changed status");

	property p_zero_flag;
		@(posedge ref_clk) disable iff (srst)
		flag_upd && !sys_wr && op_result == 40'h0000000000
		|=> st_reg.z && !st_reg.gt && !st_reg.n;
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero result flags wrong");

	property p_neg_flag;
		@(posedge ref_clk) disable iff (srst)
		flag_upd && !sys_wr && op_result[39]
		|=> st_reg.n && !st_reg.gt ##1 1'b1;
	endproperty
	a_neg_flag: assert property (p_neg_flag)
		else $error("negative result flags wrong");

	property p_smul_first;
		@(posedge ref_clk) disable iff (srst)
		src_valid && src_class == dsprf_pkg::OP_SMUL
			&& src_sel == dsprf_pkg::REG_ACC0
		|=> src_refuse && src_data == 40'h0000000000;
	endproperty
	a_smul_first: assert property (p_smul_first)
		else $error("multiply accepted first accumulator");

	property p_bad_cs;
		@(posedge ref_clk) disable iff (srst)
		st_reg.cs[2:1] == 2'b11 |-> !condition_bit;
	endproperty
	a_bad_cs: assert property (p_bad_cs)
		else $error("condition bit set under forbidden select");

	property p_sr_protect;
		@(posedge ref_clk) disable iff (srst)
		sr_load_valid && dsp_user_mode
		|=> sr_load_strobe && ((sr_load_value
			^ $past(sr_cur)) & ~dsprf_pkg::SR_USER_LOAD_MASK) == '0;
	endproperty
	a_sr_protect: assert property (p_sr_protect)
		else $error("protected status field changed");

	c_cond_skip: cover property (@(posedge ref_clk) disable iff (srst)
		op_valid && op_cond && !condition_bit);
	c_guard_load: cover property (@(posedge ref_clk) disable iff (srst)
		xfer_valid && xfer_load && xfer_reg == dsprf_pkg::REG_GRD1);
	c_dc_set: cover property (@(posedge ref_clk) disable iff (srst)
		flag_upd ##1 condition_bit);

endmodule

/* rtl/dsprf_pkg.sv */
/*
 * Shared constants and types for the DSP register file and status block.
 * Assumes one core clock and a synchronous active-high reset everywhere.
 */
// Operation
// - Protected status fields keep value on write (code: only in DSP user mode; other loads write every bit)
// - DSP user load changes repeat/modulo fields only
// - Every DSP register loads and stores singly
// - Word transfers use upper half, clear lower
// - Word load to accumulator sign-extends guard
// - Guard destination loads guard only
// - Long load to accumulator sign-extends guard
// - Fixed, shift, multiply write full forty bits
// - Integer, detect write 24 bits, clear low
// - Logical results clear guard and low half
// - Operand sources sign-extended into guard positions; multiply, logical and logical shift sources get a zero guard
// - Multiply accepts second accumulator, never first
// - Status bits 31..8 read zero
// - Signed-greater flag at bit seven
// - Zero flag at bit six
// - Negative flag at bit five
// - Overflow flag at bit four
// - Select field bits three..one picks condition
// - Condition bit reflects selected condition
// - Condition bit gates only DSP register writes
// - Unconditional data operations update flags; multiply leaves flags unchanged
// - CPU and conditional operations leave status alone
// - Status register reachable as system register
package dsprf_pkg;

	// ----------------------------------------------------------------
	// Register selects and operation classes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		REG_ACC0, REG_ACC1, REG_GRD0, REG_GRD1,
		REG_X0, REG_X1, REG_Y0, REG_Y1, REG_M0, REG_M1
	} dsprf_reg_t;

	typedef enum logic [2:0] {
		OP_FIXED, OP_ASHIFT, OP_SMUL, OP_INTEGER,
		OP_MSBDET, OP_LOGIC, OP_LSHIFT
	} dsprf_op_t;

	// ----------------------------------------------------------------
	// Status register layout
	// ----------------------------------------------------------------
	localparam int GT_BIT = 7;
	localparam int Z_BIT  = 6;
	localparam int N_BIT  = 5;
	localparam int V_BIT  = 4;
	localparam int CS_LSB = 1;
	localparam int DC_BIT = 0;
	localparam logic [7:0] DSR_RESET = 8'h00;

	localparam logic [2:0] CS_CARRY  = 3'h0;
	localparam logic [2:0] CS_NEG    = 3'h1;
	localparam logic [2:0] CS_ZERO   = 3'h2;
	localparam logic [2:0] CS_OVF    = 3'h3;
	localparam logic [2:0] CS_GREAT  = 3'h4;
	localparam logic [2:0] CS_ABOVE  = 3'h5;

	// CPU status fields a DSP user-mode load may change
	localparam logic [31:0] SR_USER_LOAD_MASK = 32'h0FFF0C0C;

	localparam int OPR_BASE = 4;

endpackage

/* rtl/dsprf_cond.sv */
/*
 * Condition bit selector: picks one condition from the flags.
 * Assumes flags given are those about to be stored.
 */
`timescale 1ns/1ps
module dsprf_cond (
	// Flags
	input  wire logic       gt,
	input  wire logic       z,
	input  wire logic       n,
	input  wire logic       v,
	input  wire logic       cy,
	// Select and result
	input  wire logic [2:0] cs,
	output logic            dc
);

	// ------------------------------------------------------------
	// Selection
	// ------------------------------------------------------------
	always_comb
	begin
		case (cs)
			dsprf_pkg::CS_CARRY: dc = cy;
			dsprf_pkg::CS_NEG:   dc = n;
			dsprf_pkg::CS_ZERO:  dc = z;
			dsprf_pkg::CS_OVF:   dc = v;
			dsprf_pkg::CS_GREAT: dc = gt;
			dsprf_pkg::CS_ABOVE: dc = ~(n ^ v) & ~z;
			default:             dc = 1'b0;
		endcase
	end

endmodule

/* rtl/dsprf_sr_guard.sv */
/*
 * Merges a CPU status load with field protection in DSP user mode.
 * Assumes the CPU applies the merged value it is handed back.
 */
`timescale 1ns/1ps
module dsprf_sr_guard (
	// Values
	input  wire logic [31:0] sr_cur,
	input  wire logic [31:0] sr_wdata,
	// Mode
	input  wire logic        dsp_user_mode,
	output logic [31:0]      sr_merged
);

	// ------------------------------------------------------------
	// Protected fields keep their old bits in DSP user mode
	// ------------------------------------------------------------
	always_comb
	begin
		if (dsp_user_mode)
			sr_merged = (sr_cur & ~dsprf_pkg::SR_USER_LOAD_MASK)
				| (sr_wdata & dsprf_pkg::SR_USER_LOAD_MASK);
		else
			sr_merged = sr_wdata;
	end

endmodule

/* tb/dsprf_cpu_model.sv */
/*
 * CPU status word model: holds the CPU status register and takes the
 * merged value handed back by the block on each load strobe.
 * Assumes the strobe and merged value are registered on ref_clk.
 */
`timescale 1ns/1ps
module dsprf_cpu_model #(
	parameter logic [31:0] SR_INIT = 32'h000000F0
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Merged load from the block
	input  wire logic        sr_load_strobe,
	input  wire logic [31:0] sr_load_value,
	// Current status word
	output logic [31:0]      sr_cur
);
	// Status word changes only through the block's merged value
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			sr_cur <= SR_INIT;
		else if (sr_load_strobe)
			sr_cur <= sr_load_value;
	end
endmodule

/* tb/tb_dsp_register_file_status.sv */
/*
 * Testbench for the DSP register file: transfers, result write-back,
 * status register, condition select, gating and status load filter.
 * Assumes the design package and the CPU model are compiled first.
 */
`timescale 1ns/1ps
module tb_dsp_register_file_status;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0, srst = 1'b1;
	logic        xfer_valid = 1'b0, xfer_load = 1'b0, xfer_long = 1'b0;
	logic [3:0]  xfer_reg = 4'h0, op_dst = 4'h0, src_sel = 4'h0;
	logic [31:0] xfer_wdata = 32'h0, sys_wdata = 32'h0, sr_wdata = 32'h0;
	logic [31:0] xfer_rdata, sys_rdata, sr_cur, sr_load_value;
	logic        op_valid = 1'b0, op_cond = 1'b0, op_carry = 1'b0;
	logic        op_ovf = 1'b0, src_valid = 1'b0, sys_valid = 1'b0;
	logic        sys_write = 1'b0, sr_load_valid = 1'b0;
	logic        dsp_user_mode = 1'b0;
	logic        src_refuse, condition_bit, sr_load_strobe;
	logic [2:0]  op_class = 3'h0, src_class = 3'h0;
	logic [39:0] op_result = 40'h0, src_data;
	int          fails = 0, cmp_count = 0;

	// Clock
	always #5 ref_clk = ~ref_clk;

	dsprf_top uut (.ref_clk(ref_clk), .srst(srst),
		.xfer_valid(xfer_valid), .xfer_load(xfer_load),
		.xfer_long(xfer_long), .xfer_reg(xfer_reg),
		.xfer_wdata(xfer_wdata), .xfer_rdata(xfer_rdata),
		.op_valid(op_valid), .op_cond(op_cond), .op_class(op_class),
		.op_dst(op_dst), .op_result(op_result), .op_carry(op_carry),
		.op_ovf(op_ovf), .src_valid(src_valid), .src_class(src_class),
		.src_sel(src_sel), .src_data(src_data), .src_refuse(src_refuse),
		.sys_valid(sys_valid), .sys_write(sys_write),
		.sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
		.condition_bit(condition_bit), .sr_load_valid(sr_load_valid),
		.dsp_user_mode(dsp_user_mode), .sr_cur(sr_cur),
		.sr_wdata(sr_wdata), .sr_load_value(sr_load_value),
		.sr_load_strobe(sr_load_strobe));

	dsprf_cpu_model cpu (.ref_clk(ref_clk), .srst(srst),
		.sr_load_strobe(sr_load_strobe), .sr_load_value(sr_load_value),
		.sr_cur(sr_cur));

	// ----------------------------------------------------------------
	// Drivers and compare
	// ----------------------------------------------------------------
	// Next falling edge: requests end, answers are settled
	task automatic tick;
		@(negedge ref_clk);
		xfer_valid = 1'b0;
		op_valid = 1'b0;
		src_valid = 1'b0;
		sys_valid = 1'b0;
		sr_load_valid = 1'b0;
	endtask

	task automatic chk(input string nm, input logic [39:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	task automatic xfer(input logic ld, lg, input logic [3:0] r,
		input logic [31:0] d);
		@(negedge ref_clk);
		{xfer_valid, xfer_load, xfer_long} = {1'b1, ld, lg};
		{xfer_reg, xfer_wdata} = {r, d};
		tick;
	endtask

	task automatic op(input logic c, input logic [2:0] k,
		input logic [3:0] r, input logic [39:0] d, input logic cy, ov);
		@(negedge ref_clk);
		{op_valid, op_cond, op_class, op_dst} = {1'b1, c, k, r};
		{op_result, op_carry, op_ovf} = {d, cy, ov};
		tick;
	endtask

	task automatic rd(input logic [2:0] k, input logic [3:0] r);
		@(negedge ref_clk);
		{src_valid, src_class, src_sel} = {1'b1, k, r};
		tick;
	endtask

	task automatic sys(input logic w, input logic [31:0] d);
		@(negedge ref_clk);
		{sys_valid, sys_write, sys_wdata} = {1'b1, w, d};
		tick;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Word, guard and long loads; long and word stores
	task automatic t_xfer;
		xfer(1'b1, 1'b0, 4'h0, 32'h00008001);
		rd(3'h0, 4'h0);
		chk("acc0 word", 40'hFF80010000, src_data);
		xfer(1'b1, 1'b0, 4'h2, 32'h00000012);
		rd(3'h0, 4'h0);
		chk("guard0 word", 40'h1280010000, src_data);
		xfer(1'b1, 1'b1, 4'h1, 32'h7FFFFFFF);
		rd(3'h0, 4'h1);
		chk("acc1 long", 40'h007FFFFFFF, src_data);
		xfer(1'b1, 1'b0, 4'h4, 32'h0000ABCD);
		rd(3'h0, 4'h4);
		chk("x0 operand", 40'hFFABCD0000, src_data);
		xfer(1'b0, 1'b1, 4'h4, 32'h0);
		chk("x0 long", 40'h00ABCD0000, {8'h00, xfer_rdata});
		xfer(1'b0, 1'b0, 4'h4, 32'h0);
		chk("x0 word", 40'h00FFFFABCD, {8'h00, xfer_rdata});
	endtask

	// Result formats, flags and multiply source
	task automatic t_results;
		op(1'b0, 3'h0, 4'h0, 40'h8012345678, 1'b1, 1'b0);
		rd(3'h0, 4'h0);
		chk("fixed", 40'h8012345678, src_data);
		sys(1'b0, 32'h0);
		chk("dsr n", 40'h21, {8'h00, sys_rdata});
		op(1'b0, 3'h3, 4'h1, 40'h0087654321, 1'b1, 1'b1);
		rd(3'h0, 4'h1);
		chk("integer", 40'hFF87650000, src_data);
		sys(1'b0, 32'h0);
		chk("dsr gt v", 40'h91, {8'h00, sys_rdata});
		op(1'b0, 3'h5, 4'h0, 40'hFFABCD1234, 1'b1, 1'b0);
		rd(3'h0, 4'h0);
		chk("logical", 40'h00ABCD0000, src_data);
		op(1'b0, 3'h2, 4'h8, 40'h0, 1'b0, 1'b1);
		sys(1'b0, 32'h0);
		chk("dsr mul", 40'h21, {8'h00, sys_rdata});
		rd(3'h2, 4'h0);
		chk("mul acc0", 40'h1, {39'h0, src_refuse});
		rd(3'h2, 4'h1);
		chk("mul acc1", 40'h0, {39'h0, src_refuse});
	endtask

	// Every select code; carry was left set by the logical result
	task automatic t_select;
		logic [7:0] dcx;
		dcx = 8'b00011001;
		for (int c = 0; c < 8; c++)
		begin
			sys(1'b1, {24'h0, 4'h9, c[2:0], 1'b0});
			chk("dc", {39'h0, dcx[c]}, {39'h0, condition_bit});
			sys(1'b0, 32'h0);
			chk("dsr", {32'h0, 4'h9, c[2:0], dcx[c]},
				{8'h00, sys_rdata});
		end
	endtask

	// Conditional result suppressed, then allowed; status untouched
	task automatic t_cond;
		sys(1'b1, 32'h00000004);
		op(1'b1, 3'h0, 4'h5, 40'h0011112222, 1'b1, 1'b1);
		rd(3'h0, 4'h5);
		chk("x1 held", 40'h0, src_data);
		sys(1'b1, 32'h00000044);
		chk("dc zero", 40'h1, {39'h0, condition_bit});
		op(1'b1, 3'h0, 4'h5, 40'h0011112222, 1'b0, 1'b1);
		rd(3'h0, 4'h5);
		chk("x1 written", 40'h0011112222, src_data);
		sys(1'b0, 32'h0);
		chk("dsr cond", 40'h45, {8'h00, sys_rdata});
	endtask

	// User-mode status load keeps protected fields
	task automatic t_sr;
		logic [31:0] e;
		e = (32'h000000F0 & ~dsprf_pkg::SR_USER_LOAD_MASK) |
			dsprf_pkg::SR_USER_LOAD_MASK;
		@(negedge ref_clk);
		{sr_load_valid, dsp_user_mode, sr_wdata} = {2'b11, 32'hFFFFFFFF};
		tick;
		chk("strobe", 40'h1, {39'h0, sr_load_strobe});
		chk("user load", {8'h00, e}, {8'h00, sr_load_value});
		@(negedge ref_clk);
		{sr_load_valid, dsp_user_mode, sr_wdata} = {2'b10, 32'h12345678};
		tick;
		chk("sup load", 40'h12345678, {8'h00, sr_load_value});
	endtask

	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		fails++;
		test_done;
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		srst = 1'b0;
		sys(1'b0, 32'h0);
		chk("dsr reset", 40'h0, {8'h00, sys_rdata});
		t_xfer;
		t_results;
		t_select;
		t_cond;
		t_sr;
		test_done;
	end
endmodule
